// [rtl/dcs_channel.sv]
// Purpose: per-channel control and status of a linked-list dma channel
// Assumes: apb slave; data mover external, signalled by beat/issue/resp strobes
// Notes: control block fields are loaded through apb registers standing in for the fetch
`timescale 1ns/1ns
// Function
// - writing one to bit 31 resets the channel; bit self-clears, reads zero
// - writing one to bit 30 abandons block, loads next block; self-clears
// - ignore_halt set keeps channel running during halt_request
// - drain mode counts writes vs responses, waits last response before completion
// - while draining load next pointer, clear run if zero, defer flags
// - drain mode stalls traffic while more than 13 writes outstanding
// - urgent_level field 23:20 driven when selected urgent signal is one
// - normal priority field 19:16 driven when selected urgent signal is zero
// - reserved bits 27:24, 15:9, 7 written zero, read as zero here
// - bit 8 reads one while any debug error flag is set
// - draining_flag bit 6 high while waiting for write responses
// - request_stall_flag bit 5 high while stalled by inactive data_request
// - bit 4 paused when run off, waits, halt, or write limit
// - bit 3 mirrors selected data_request after block load
// - pacing_select zero makes bit 3 read one once a block has loaded
// - irq_flag sets at block completion with irq_on_done; write one clears
// - block_done_flag sets at block completion; write one clears
// - transfers begin only with run_enable set and pointer non-zero
// - clearing run_enable pauses, setting resumes from same point
// - run_enable clears itself after zero next pointer loaded
module dcs_channel
#(
    parameter int unsigned NUM_PERIPH = 32
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dcs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic halt_request,
    input wire logic [NUM_PERIPH-1:0] data_request,
    input wire logic [NUM_PERIPH-1:0] urgent,
    input wire logic xfer_beat,
    input wire logic xfer_last,
    input wire logic wr_issue,
    input wire logic wr_resp,
    output logic move_enable,
    output logic [3:0] axi_priority,
    output logic block_load
);
    import dcs_pkg::*;

    dcs_state_t state_q;
    logic run_q, ign_halt_q, drain_q, done_q, irq_q;
    logic [3:0] urg_lvl_q, pri_q;
    logic [31:0] blk_ptr_q, next_ptr_q, xinfo_q;
    logic [2:0] debug_err_q;
    logic [4:0] wait_cnt_q;
    logic loaded_q;
    logic [CNT_W-1:0] outstanding;
    logic wr_acc, rd_acc, cs_wr, chan_rst, abort_cmd, over_limit, halted;
    logic sel_req, sel_urgent, paused, stalled, draining;
    logic blk_end, set_done, set_irq;
    logic [4:0] pace;
    logic [31:0] cs_rd;

    // apb strobes: zero-wait slave
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && !penable && !pwrite;
    assign cs_wr = wr_acc && paddr == OFS_CTRL_STATUS;
    assign chan_rst = cs_wr && pwdata[BIT_CHAN_RESET];
    assign abort_cmd = cs_wr && pwdata[BIT_ABORT];
    assign pace = xinfo_q[TI_PACE_HI:TI_PACE_LO];
    assign sel_req = (pace == 5'h00) ? 1'b1 : data_request[pace];
    assign sel_urgent = (pace == 5'h00) ? 1'b0 : urgent[pace];
    assign halted = halt_request && !ign_halt_q;
    assign over_limit = drain_q && outstanding > CNT_W'(MAX_OUTSTANDING);
    assign draining = state_q == ST_DRAIN;
    assign stalled = state_q == ST_MOVE && !sel_req;
    assign paused = !run_q || state_q == ST_WAIT || halted || over_limit;
    assign blk_end = state_q == ST_MOVE && xfer_beat && xfer_last;
    // completion, deferred while responses are still owed
    assign set_done = (state_q == ST_END) || (draining && outstanding == '0);
    assign set_irq = set_done && xinfo_q[TI_IRQ_ON_DONE];

    dcs_wr_counter #(.W(CNT_W)) dcs_wr_counter_inst
    (
        .pclk(pclk),
        .presetn(presetn),
        .ce(clk_en),
        .clr(chan_rst),
        .issue(wr_issue && drain_q),
        .resp(wr_resp && drain_q),
        .count(outstanding)
    );

    // channel sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ST_IDLE;
            wait_cnt_q <= '0;
            loaded_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (chan_rst)
            begin
                state_q <= ST_IDLE;
                wait_cnt_q <= '0;
                loaded_q <= 1'b0;
            end
            else if (abort_cmd && state_q != ST_IDLE)
            begin
                state_q <= ST_END;
            end
            else
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        if (run_q && blk_ptr_q != 32'h0)
                        begin
                            state_q <= ST_MOVE;
                            loaded_q <= 1'b1;
                        end
                    end
                    ST_MOVE:
                    begin
                        if (blk_end)
                            state_q <= drain_q ? ST_DRAIN : ST_END;
                        else if (xfer_beat && xinfo_q[TI_WAITS_HI:TI_WAITS_LO] != 5'h00)
                        begin
                            state_q <= ST_WAIT;
                            wait_cnt_q <= xinfo_q[TI_WAITS_HI:TI_WAITS_LO];
                        end
                    end
                    ST_WAIT:
                    begin
                        if (run_q && !halted)
                        begin
                            wait_cnt_q <= wait_cnt_q - 5'h01;
                            if (wait_cnt_q == 5'h01)
                                state_q <= ST_MOVE;
                        end
                    end
                    ST_DRAIN:
                    begin
                        if (outstanding == '0)
                        begin
                            state_q <= ST_IDLE;
                        end
                    end
                    ST_END:
                    begin
                        // request mirror stays valid until a channel reset
                        state_q <= ST_IDLE;
                    end
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // control fields, run bit and block pointers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run_q <= RST_WORD[BIT_RUN];
            ign_halt_q <= RST_WORD[BIT_IGNORE_HALT];
            drain_q <= RST_WORD[BIT_DRAIN_MODE];
            urg_lvl_q <= RST_WORD[URG_HI:URG_LO];
            pri_q <= RST_WORD[PRI_HI:PRI_LO];
            blk_ptr_q <= RST_WORD;
            next_ptr_q <= RST_WORD;
            xinfo_q <= RST_WORD;
        end
        else if (clk_en)
        begin
            if (chan_rst)
            begin
                run_q <= 1'b0;
                ign_halt_q <= 1'b0;
                drain_q <= 1'b0;
                urg_lvl_q <= '0;
                pri_q <= '0;
                blk_ptr_q <= '0;
                next_ptr_q <= '0;
                xinfo_q <= '0;
            end
            else
            begin
                if (cs_wr)
                begin
                    run_q <= pwdata[BIT_RUN];
                    ign_halt_q <= pwdata[BIT_IGNORE_HALT];
                    drain_q <= pwdata[BIT_DRAIN_MODE];
                    urg_lvl_q <= pwdata[URG_HI:URG_LO];
                    pri_q <= pwdata[PRI_HI:PRI_LO];
                end
                if (wr_acc && paddr == OFS_BLOCK_PTR)
                    blk_ptr_q <= pwdata;
                if (wr_acc && paddr == OFS_XFER_INFO)
                    xinfo_q <= pwdata;
                if (wr_acc && paddr == OFS_NEXT_PTR)
                    next_ptr_q <= pwdata;
                // next pointer loaded at block end, without a fetch when draining
                if (blk_end || (abort_cmd && state_q != ST_IDLE))
                begin
                    blk_ptr_q <= next_ptr_q;
                    if (next_ptr_q == 32'h0)
                        run_q <= 1'b0;
                end
            end
        end
    end

    // sticky done and irq flags; a set beats a same-cycle clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_q <= RST_WORD[BIT_DONE];
            irq_q <= RST_WORD[BIT_IRQ];
        end
        else if (clk_en)
        begin
            if (chan_rst)
            begin
                done_q <= 1'b0;
                irq_q <= 1'b0;
            end
            else
            begin
                done_q <= set_done || (done_q && !(cs_wr && pwdata[BIT_DONE]));
                irq_q <= set_irq || (irq_q && !(cs_wr && pwdata[BIT_IRQ]));
            end
        end
    end

    // debug error flags: hardware sets, write one clears
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            debug_err_q <= '0;
        else if (clk_en)
        begin
            if (chan_rst)
                debug_err_q <= '0;
            else
                debug_err_q <= (debug_err_q & ~((wr_acc && paddr == OFS_DEBUG) ? pwdata[2:0] : 3'h0))
                    | {1'b0, wr_resp && !drain_q && 1'b0, wr_resp && drain_q && outstanding == '0};
        end
    end

    // control/status read image, reserved bits zero
    always_comb
    begin
        cs_rd = '0;
        cs_rd[BIT_IGNORE_HALT] = ign_halt_q;
        cs_rd[BIT_DRAIN_MODE] = drain_q;
        cs_rd[URG_HI:URG_LO] = urg_lvl_q;
        cs_rd[PRI_HI:PRI_LO] = pri_q;
        cs_rd[BIT_ERROR] = |debug_err_q;
        cs_rd[BIT_DRAINING] = draining;
        cs_rd[BIT_REQ_STALL] = stalled;
        cs_rd[BIT_PAUSED] = paused;
        cs_rd[BIT_DATA_REQ] = loaded_q && sel_req;
        cs_rd[BIT_IRQ] = irq_q;
        cs_rd[BIT_DONE] = done_q;
        cs_rd[BIT_RUN] = run_q;
    end

    // apb read data, sampled in setup, held through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end
        else if (clk_en)
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr > OFS_DEBUG;
            if (rd_acc)
            begin
                case (paddr)
                    OFS_CTRL_STATUS: prdata <= cs_rd;
                    OFS_BLOCK_PTR: prdata <= blk_ptr_q;
                    OFS_XFER_INFO: prdata <= xinfo_q;
                    OFS_NEXT_PTR: prdata <= next_ptr_q;
                    OFS_DEBUG: prdata <= {29'h0, debug_err_q};
                    default: prdata <= '0;
                endcase
            end
        end
    end

    // mover controls
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            move_enable <= 1'b0;
            axi_priority <= '0;
            block_load <= 1'b0;
        end
        else if (clk_en)
        begin
            move_enable <= state_q == ST_MOVE && !paused && sel_req && !chan_rst;
            axi_priority <= sel_urgent ? urg_lvl_q : pri_q;
            block_load <= state_q == ST_IDLE && run_q && blk_ptr_q != 32'h0 && !chan_rst;
        end
    end
endmodule

// [shared/dcs_pkg.sv]
// Purpose: constants and types for the dma channel control/status block
// Assumes: apb with 32-bit data, one word per register
// Notes: offsets are byte addresses
package dcs_pkg;
    localparam int unsigned ADDR_W = 8;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL_STATUS = 8'h00;
    localparam logic [7:0] OFS_BLOCK_PTR = 8'h04;
    localparam logic [7:0] OFS_XFER_INFO = 8'h08;
    localparam logic [7:0] OFS_NEXT_PTR = 8'h0c;
    localparam logic [7:0] OFS_DEBUG = 8'h10;
    // control/status field positions
    localparam int unsigned BIT_CHAN_RESET = 31;
    localparam int unsigned BIT_ABORT = 30;
    localparam int unsigned BIT_IGNORE_HALT = 29;
    localparam int unsigned BIT_DRAIN_MODE = 28;
    localparam int unsigned URG_HI = 23;
    localparam int unsigned URG_LO = 20;
    localparam int unsigned PRI_HI = 19;
    localparam int unsigned PRI_LO = 16;
    localparam int unsigned BIT_ERROR = 8;
    localparam int unsigned BIT_DRAINING = 6;
    localparam int unsigned BIT_REQ_STALL = 5;
    localparam int unsigned BIT_PAUSED = 4;
    localparam int unsigned BIT_DATA_REQ = 3;
    localparam int unsigned BIT_IRQ = 2;
    localparam int unsigned BIT_DONE = 1;
    localparam int unsigned BIT_RUN = 0;
    // transfer-info fields
    localparam int unsigned TI_IRQ_ON_DONE = 0;
    localparam int unsigned TI_WAITS_HI = 25;
    localparam int unsigned TI_WAITS_LO = 21;
    localparam int unsigned TI_PACE_HI = 20;
    localparam int unsigned TI_PACE_LO = 16;
    // reset value of every stored field
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // outstanding write limit
    localparam int unsigned MAX_OUTSTANDING = 13;
    localparam int unsigned CNT_W = 5;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_MOVE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DRAIN = 3'b011,
        ST_END = 3'b100
    } dcs_state_t;
endpackage

// [rtl/dcs_wr_counter.sv]
// Purpose: count axi writes issued against write responses
// Assumes: a response never arrives with nothing outstanding
// Notes: cleared by channel reset
`timescale 1ns/1ns
module dcs_wr_counter
#(
    parameter int unsigned W = dcs_pkg::CNT_W
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic clr,
    input wire logic issue,
    input wire logic resp,
    output logic [W-1:0] count
);
    import dcs_pkg::*;
    // up on issue, down on response, both cancel
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            count <= '0;
        else if (ce)
        begin
            if (clr)
                count <= '0;
            else if (issue && !resp)
                count <= count + W'(1);
            else if (resp && !issue && count != '0)
                count <= count - W'(1);
        end
    end
endmodule

// [verif/dcs_channel_sva.sv]
// Purpose: port assertions for the channel control/status block
// Assumes: each apb access is one setup and one access cycle
// Notes: shadows of written fields live in helper logic
`timescale 1ns/1ns
module dcs_channel_sva
import dcs_pkg::*;
#(
    parameter int unsigned NUM_PERIPH = 32
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dcs_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic halt_request,
    input wire logic [NUM_PERIPH-1:0] urgent,
    input wire logic wr_issue,
    input wire logic wr_resp,
    input wire logic move_enable,
    input wire logic [3:0] axi_priority,
    input wire logic block_load
);
    logic [7:0] pri_q;
    logic [4:0] sel_q;
    logic [4:0] cnt_q;
    logic ign_q;
    logic drn_q;
    logic ld_q;
    logic wr;
    logic rd_cs;
    logic crst;
    // completed accesses
    assign wr = psel && penable && pready && pwrite;
    assign rd_cs = psel && penable && pready && !pwrite && paddr == OFS_CTRL_STATUS;
    assign crst = wr && paddr == OFS_CTRL_STATUS && pwdata[BIT_CHAN_RESET];
    // shadow of written fields and outstanding writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {pri_q, sel_q, cnt_q, ign_q, drn_q, ld_q} <= '0;
        else if (crst)
            {pri_q, sel_q, cnt_q, ign_q, drn_q, ld_q} <= '0;
        else
        begin
            if (wr && paddr == OFS_CTRL_STATUS)
                {ign_q, drn_q, pri_q} <= {pwdata[BIT_IGNORE_HALT:BIT_DRAIN_MODE], pwdata[URG_HI:PRI_LO]};
            if (wr && paddr == OFS_XFER_INFO)
                sel_q <= pwdata[TI_PACE_HI:TI_PACE_LO];
            if (block_load)
                ld_q <= 1'b1;
            if (drn_q)
                cnt_q <= cnt_q + 5'(wr_issue) - 5'(wr_resp && cnt_q != 5'd0);
        end
    end
    default clocking dcs_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_cmd;
        rd_cs |-> prdata[31:30] == 2'b00;
    endproperty
    a_cmd: assert property (p_cmd) else $error("command bits read as one");
    property p_rsvd;
        rd_cs |-> {prdata[27:24], prdata[15:9], prdata[7]} == 12'h000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
    property p_prio;
        move_enable && $stable(urgent) |->
            axi_priority == ((sel_q != 5'd0 && urgent[sel_q]) ? pri_q[7:4] : pri_q[3:0]);
    endproperty
    a_prio: assert property (p_prio) else $error("wrong bus priority");
    property p_halt;
        halt_request && $past(halt_request) && !ign_q && !$past(ign_q) |-> !move_enable;
    endproperty
    a_halt: assert property (p_halt) else $error("moving during halt");
    property p_lim;
        cnt_q > 5'd13 && $past(cnt_q) > 5'd13 |-> !move_enable;
    endproperty
    a_lim: assert property (p_lim) else $error("moving over write limit");
    property p_unpaced;
        rd_cs && ld_q && sel_q == 5'd0 |-> prdata[BIT_DATA_REQ];
    endproperty
    a_unpaced: assert property (p_unpaced) else $error("unpaced request bit low");
    property p_crst;
        crst |-> ##2 !move_enable && !block_load;
    endproperty
    a_crst: assert property (p_crst) else $error("transfer survives channel reset");
    property p_rstv;
        !$past(presetn) |-> !move_enable && !block_load && axi_priority == 4'h0;
    endproperty
    a_rstv: assert property (p_rstv) else $error("outputs not zero after reset");
endmodule
bind dcs_channel dcs_channel_sva #(.NUM_PERIPH(NUM_PERIPH)) dcs_channel_sva_inst
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .halt_request, .urgent, .wr_issue, .wr_resp, .move_enable, .axi_priority, .block_load
);

// [verif/dcs_far_model.sv]
// Purpose: far side: data mover beats and axi write responses
// Assumes: one write per beat, moving only while move_enable is high
// Notes: hold stalls responses so writes pile up
`timescale 1ns/1ns
module dcs_far_model
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic move_enable,
    input wire logic [4:0] beats,
    input wire logic hold,
    output logic xfer_beat,
    output logic xfer_last,
    output logic wr_issue,
    output logic wr_resp
);
    logic [4:0] n_q;
    logic [5:0] pend_q;
    logic fin_q;
    // a beat and a write each enabled cycle until the block's last
    assign xfer_beat = move_enable && !fin_q;
    assign xfer_last = xfer_beat && n_q == beats - 5'd1;
    assign wr_issue = xfer_beat;
    // one response a cycle while any is owed and hold is low
    assign wr_resp = pend_q != 6'd0 && !hold;
    // beat position, end latch, owed responses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            n_q <= 5'd0;
            pend_q <= 6'd0;
            fin_q <= 1'b0;
        end
        else
        begin
            pend_q <= pend_q + 6'(wr_issue) - 6'(wr_resp);
            fin_q <= move_enable && (fin_q || xfer_last);
            if (xfer_last)
                n_q <= 5'd0;
            else if (xfer_beat)
                n_q <= n_q + 5'd1;
        end
    end
endmodule

// [verif/test_dma_channel_control_status.sv]
// Purpose: self-checking bench for the channel control/status block
// Assumes: far-side model moves the data
// Notes: read expectations queue up, checked at the access edge
`timescale 1ns/1ns
module test_dma_channel_control_status;
    import dcs_pkg::*;
    localparam logic [7:0] CSR = OFS_CTRL_STATUS;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic halt_request = 1'b0;
    logic [31:0] data_request = 32'h0;
    logic [31:0] urgent = 32'h0;
    logic [4:0] beats = 5'd3;
    logic hold = 1'b0;
    logic [31:0] prdata;
    logic [3:0] axi_priority;
    logic pready, pslverr, xfer_beat, xfer_last, wr_issue, wr_resp, move_enable, block_load;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    logic [32:0] msk = '1;
    logic [32:0] m;
    logic [31:0] base;
    int error_cnt = 0;
    int compares = 0;
    int cyc = 0;
    always #10 pclk = ~pclk;
    dcs_channel dcs_channel_inst (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .halt_request, .data_request, .urgent, .xfer_beat,
        .xfer_last, .wr_issue, .wr_resp, .move_enable, .axi_priority, .block_load);
    dcs_far_model dcs_far_model_inst (.pclk, .presetn, .move_enable, .beats, .hold, .xfer_beat,
        .xfer_last, .wr_issue, .wr_resp);
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value read data: expected %h seen %h", exp, seen);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // one apb transfer and an idle cycle; a read queues {pslverr, prdata}
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        if (!w)
        begin
            exp_q.push_back({a > OFS_DEBUG, d});
            msk_q.push_back(msk);
        end
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // wait for the block's last beat and the flag update behind it
    task automatic wait_end;
        while (!(xfer_beat && xfer_last))
            @(posedge pclk);
        repeat (3) @(posedge pclk);
    endtask
    // compare each read against the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1 && !pwrite)
        begin
            m = msk_q.pop_front();
            check({pslverr, prdata} & m, exp_q.pop_front() & m);
        end
    end
    // cut a hang short
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc > 20000)
        begin
            error_cnt++;
            test_done();
        end
    end
    // main sequence
    initial
    begin
        void'($urandom(32'h77dbb2f2));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        acc(1'b0, CSR, 32'h10);
        acc(1'b0, 8'h14, 32'h0);
        $display("test reset values done");
        base = {4'b0010, 4'h0, 8'($urandom), 16'h0};
        msk = 33'h1_ffff_ffef;
        acc(1'b1, CSR, base | 32'h4000_0000);
        acc(1'b0, CSR, base);
        $display("test field readback done");
        halt_request <= 1'b1;
        urgent <= $urandom;
        acc(1'b1, OFS_XFER_INFO, 32'h1);
        acc(1'b1, OFS_BLOCK_PTR, 32'h100);
        acc(1'b1, CSR, base | 32'h1);
        wait_end();
        acc(1'b0, CSR, base | 32'he);
        data_request <= $urandom | 32'h20;
        urgent <= $urandom;
        acc(1'b1, OFS_XFER_INFO, 32'h0005_0000);
        acc(1'b1, OFS_BLOCK_PTR, 32'h100);
        acc(1'b1, CSR, base | 32'h1);
        wait_end();
        acc(1'b0, CSR, base | 32'he);
        data_request[5] <= 1'b0;
        acc(1'b0, CSR, base | 32'h6);
        acc(1'b1, CSR, base | 32'h6);
        acc(1'b0, CSR, base);
        $display("test blocks and flags done");
        base[29] = 1'b0;
        data_request[5] <= 1'b1;
        acc(1'b1, OFS_BLOCK_PTR, 32'h200);
        acc(1'b1, CSR, base | 32'h1);
        msk = 33'h1_ffff_ffd7;
        acc(1'b0, CSR, base | 32'h11);
        halt_request <= 1'b0;
        acc(1'b1, CSR, base);
        acc(1'b0, CSR, base | 32'h10);
        msk = 33'h1_ffff_ffef;
        acc(1'b1, CSR, base | 32'h1);
        wait_end();
        acc(1'b0, CSR, base | 32'ha);
        $display("test halt and pause done");
        base[28] = 1'b1;
        beats <= 5'd16;
        hold <= 1'b1;
        acc(1'b1, OFS_XFER_INFO, 32'h1);
        acc(1'b1, OFS_BLOCK_PTR, 32'h300);
        acc(1'b1, CSR, base | 32'h3);
        repeat (30) @(posedge pclk);
        msk = 33'h1_ffff_ffbf;
        acc(1'b0, CSR, base | 32'h19);
        hold <= 1'b0;
        repeat (4) @(posedge pclk);
        hold <= 1'b1;
        wait_end();
        msk = 33'h1_ffff_ffef;
        acc(1'b0, CSR, base | 32'h48);
        hold <= 1'b0;
        repeat (30) @(posedge pclk);
        acc(1'b0, CSR, base | 32'he);
        $display("test drain mode done");
        halt_request <= 1'b1;
        acc(1'b1, OFS_BLOCK_PTR, 32'h400);
        acc(1'b1, CSR, base | 32'h1);
        acc(1'b1, CSR, base | 32'h4000_0007);
        acc(1'b0, CSR, base | 32'he);
        acc(1'b1, CSR, 32'h8000_0000);
        halt_request <= 1'b0;
        acc(1'b0, CSR, 32'h0);
        $display("test channel reset done");
        test_done();
    end
endmodule
